// file: include/wcac_pkg.sv
// Constants, register map and carrier types for the weld cycle and alarm controller.
// Assumes a 100 MHz system clock and a classic Wishbone slave with 32-bit data.
package wcac_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEEK_PERIOD_S = 60;
  localparam int SEEK_PERIOD_MS = SEEK_PERIOD_S * 1000;
  localparam int POWER_SETTLE_S = 1;
  localparam int POWER_SETTLE_MS = POWER_SETTLE_S * 1000;
  localparam int ALARM_W = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AMP = 8'h04;
  localparam logic [7:0] REG_OFS = 8'h08;
  localparam logic [7:0] REG_RAMP = 8'h0C;
  localparam logic [7:0] REG_SEEK = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_TUNE = 8'h18;
  localparam logic [7:0] REG_IRQ_ST = 8'h1C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  // Control field positions
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_AMP_EXT = 1;
  localparam int CTRL_OFS_EXT = 2;
  localparam int CTRL_EOC_STORE = 3;
  localparam int CTRL_TIMED_SEEK = 4;
  localparam int CTRL_W = 5;
  // Interrupt event positions
  localparam int EV_ALARM = 0;
  localparam int EV_START = 1;
  localparam int EV_END = 2;
  localparam int EV_SEEK = 3;
  localparam int EV_PWR = 4;
  localparam int EV_W = 5;
  // Reset values and limits
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [6:0] AMP_MIN = 7'h0A;
  localparam logic [6:0] AMP_MAX = 7'h64;
  localparam logic [6:0] AMP_DFLT = 7'h32;
  localparam logic [6:0] AMP_RST = 7'h64;
  localparam logic [15:0] RAMP_RST = 16'h0A0A;
  localparam logic [15:0] SEEK_TIME_RST = 16'h0032;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WELD = 3'b010,
    ST_SEEK = 3'b100
  } wcac_state_e;

  typedef struct packed {
    logic start;
    logic seek;
    logic clr;
    logic key;
    logic line_ok;
    logic logic_ok;
    logic amp_ok;
    logic ofs_ok;
    logic [ALARM_W-1:0] fault;
  } wcac_pins_s;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [6:0] amp;
    logic [11:0] ofs;
    logic [7:0] start_ramp;
    logic [7:0] seek_ramp;
    logic [15:0] seek_time;
    logic [EV_W-1:0] mask;
  } wcac_cfg_s;
endpackage : wcac_pkg

// file: core/wcac_core.sv
// Weld cycle, alarm policy, ramps and timed seeks behind a Wishbone register file.
// Assumes digital pins are asynchronous and analog words come from an ADC on clk.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module wcac_core import wcac_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int SEEK_PERIOD_TICKS = SEEK_PERIOD_MS,
  parameter int POWER_SETTLE_TICKS = POWER_SETTLE_MS,
  parameter int FREQ_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // User I/O pins
  input wire logic ext_start_in,
  input wire logic ext_seek_in,
  input wire logic ext_fault_clr_in,
  input wire logic panel_reset_key_in,
  input wire logic line_power_ok_in,
  input wire logic logic_supply_ok_in,
  input wire logic [ALARM_W-1:0] fault_cond_in,
  input wire logic amp_in_valid,
  input wire logic ofs_in_valid,
  // Analog words, clk domain
  input wire logic [6:0] amp_in,
  input wire logic [11:0] ofs_in,
  input wire logic [FREQ_W-1:0] meas_freq_in,
  // Outputs
  output logic sonics_on,
  output logic ready_out,
  output logic fault_out,
  output logic seek_scan_out,
  output logic [6:0] amp_level,
  output logic [11:0] freq_offset,
  output logic irq
);
  function automatic logic pct_ok(input logic [6:0] v);
    pct_ok = (v >= AMP_MIN) && (v <= AMP_MAX);
  endfunction : pct_ok

  // Two-flop synchronisers; stage one feeds stage two only
  wcac_pins_s sync1_ff, sync2_ff, prev_ff;
  wcac_pins_s pins_raw;
  always_comb begin
    pins_raw = '0;
    pins_raw.start = ext_start_in;
    pins_raw.seek = ext_seek_in;
    pins_raw.clr = ext_fault_clr_in;
    pins_raw.key = panel_reset_key_in;
    pins_raw.line_ok = line_power_ok_in;
    pins_raw.logic_ok = logic_supply_ok_in;
    pins_raw.amp_ok = amp_in_valid;
    pins_raw.ofs_ok = ofs_in_valid;
    pins_raw.fault = fault_cond_in;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  logic start_rise, seek_rise, logic_rise;
  assign start_rise = sync2_ff.start && !prev_ff.start;
  assign seek_rise = sync2_ff.seek && !prev_ff.seek;
  assign logic_rise = sync2_ff.logic_ok && !prev_ff.logic_ok;

  // Millisecond tick keeps the long timers narrow
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;
  always_comb begin
    tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // Register file and bus
  wcac_cfg_s cfg_ff, nxt_cfg;
  logic [EV_W-1:0] irq_st_ff, nxt_irq_st, ev;
  logic [31:0] dat_ff, nxt_dat, rd_mux;
  logic ack_ff, nxt_ack;
  logic [FREQ_W-1:0] tune_ff, nxt_tune;
  wcac_state_e state_ff, nxt_state;
  logic alarm_ff, nxt_alarm;
  logic wr_go;
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      REG_CTRL: rd_mux[CTRL_W-1:0] = cfg_ff.ctrl;
      REG_AMP: rd_mux[6:0] = cfg_ff.amp;
      REG_OFS: rd_mux[11:0] = cfg_ff.ofs;
      REG_RAMP: rd_mux[15:0] = {cfg_ff.seek_ramp, cfg_ff.start_ramp};
      REG_SEEK: rd_mux[15:0] = cfg_ff.seek_time;
      REG_STATUS: rd_mux[6:0] = {state_ff, seek_scan_out, alarm_ff, ready_out, sonics_on};
      REG_TUNE: rd_mux[FREQ_W-1:0] = tune_ff;
      REG_IRQ_ST: rd_mux[EV_W-1:0] = irq_st_ff;
      REG_IRQ_MASK: rd_mux[EV_W-1:0] = cfg_ff.mask;
      default: rd_mux = 32'h0000_0000;
    endcase
    // Ack one cycle after the strobe; the write lands on the edge that samples ack
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_dat = nxt_ack ? rd_mux : dat_ff;
    nxt_cfg = cfg_ff;
    if (wr_go && wb_sel_i[0]) begin
      case (wb_adr_i)
        REG_CTRL: nxt_cfg.ctrl = wb_dat_i[CTRL_W-1:0];
        REG_AMP: nxt_cfg.amp = pct_ok(wb_dat_i[6:0]) ? wb_dat_i[6:0] : cfg_ff.amp;
        REG_OFS: nxt_cfg.ofs[7:0] = wb_dat_i[7:0];
        REG_RAMP: nxt_cfg.start_ramp = wb_dat_i[7:0];
        REG_SEEK: nxt_cfg.seek_time[7:0] = wb_dat_i[7:0];
        REG_IRQ_MASK: nxt_cfg.mask = wb_dat_i[EV_W-1:0];
        default: nxt_cfg = cfg_ff;
      endcase
    end
    if (wr_go && wb_sel_i[1]) begin
      case (wb_adr_i)
        REG_OFS: nxt_cfg.ofs[11:8] = wb_dat_i[11:8];
        REG_RAMP: nxt_cfg.seek_ramp = wb_dat_i[15:8];
        REG_SEEK: nxt_cfg.seek_time[15:8] = wb_dat_i[15:8];
        default: nxt_cfg.ofs = nxt_cfg.ofs;
      endcase
    end
    // Write one to clear; a new event in the same cycle wins
    nxt_irq_st = irq_st_ff;
    if (wr_go && wb_sel_i[0] && (wb_adr_i == REG_IRQ_ST)) nxt_irq_st = irq_st_ff & ~wb_dat_i[EV_W-1:0];
    nxt_irq_st = nxt_irq_st | ev;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '{ctrl: CTRL_RST, amp: AMP_RST, ofs: 12'h000, start_ramp: RAMP_RST[7:0],
                  seek_ramp: RAMP_RST[15:8], seek_time: SEEK_TIME_RST, mask: '0};
      irq_st_ff <= '0;
      dat_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      irq_st_ff <= nxt_irq_st;
      dat_ff <= nxt_dat;
      ack_ff <= nxt_ack;
    end
  end
  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign irq = |(irq_st_ff & cfg_ff.mask);

  // Power-on check: line power must settle before the logic supply appears
  logic [31:0] line_cnt_ff, nxt_line_cnt;
  logic pwr_alarm;
  always_comb begin
    nxt_line_cnt = line_cnt_ff;
    if (!sync2_ff.line_ok) nxt_line_cnt = 32'h0000_0000;
    else if (tick && (line_cnt_ff < 32'(POWER_SETTLE_TICKS))) nxt_line_cnt = line_cnt_ff + 32'h0000_0001;
    pwr_alarm = logic_rise && (line_cnt_ff < 32'(POWER_SETTLE_TICKS));
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_cnt_ff <= 32'h0000_0000;
    end else begin
      line_cnt_ff <= nxt_line_cnt;
    end
  end

  // Setpoint and offset selection; invalid analog input falls back to defaults
  logic [6:0] amp_set;
  logic [11:0] ofs_set;
  always_comb begin
    if (!cfg_ff.ctrl[CTRL_AMP_EXT]) amp_set = cfg_ff.amp;
    else if (sync2_ff.amp_ok && pct_ok(amp_in)) amp_set = amp_in;
    else amp_set = AMP_DFLT;
    if (!cfg_ff.ctrl[CTRL_OFS_EXT]) ofs_set = cfg_ff.ofs;
    else if (sync2_ff.ofs_ok) ofs_set = ofs_in;
    else ofs_set = 12'h000;
  end

  // Cycle sequencer with alarm policy, ramp and seek timers
  logic [6:0] amp_ff, nxt_amp;
  logic [11:0] ofs_ff, nxt_ofs;
  logic [7:0] step_ff, nxt_step;
  logic [15:0] seek_cnt_ff, nxt_seek_cnt;
  logic [31:0] per_cnt_ff, nxt_per_cnt;
  logic seek_due, alarm_set, alarm_clr, latch, may_start, clr_by_start;
  logic [7:0] step_len;
  always_comb begin
    latch = cfg_ff.ctrl[CTRL_LATCH];
    alarm_set = (|sync2_ff.fault) || pwr_alarm;
    clr_by_start = !latch && start_rise;
    alarm_clr = (latch && (sync2_ff.key || sync2_ff.clr)) || clr_by_start;
    // Set beats clear so a fault in the clearing cycle is never lost
    nxt_alarm = alarm_set || (alarm_ff && !alarm_clr);
    may_start = !alarm_set && (!alarm_ff || clr_by_start);
    seek_due = cfg_ff.ctrl[CTRL_TIMED_SEEK] && (per_cnt_ff >= 32'(SEEK_PERIOD_TICKS));
    step_len = (state_ff == ST_SEEK) ? cfg_ff.seek_ramp : cfg_ff.start_ramp;
    nxt_state = state_ff;
    nxt_amp = amp_ff;
    nxt_ofs = ofs_ff;
    nxt_step = step_ff;
    nxt_seek_cnt = seek_cnt_ff;
    nxt_per_cnt = (tick && (per_cnt_ff < 32'(SEEK_PERIOD_TICKS))) ? per_cnt_ff + 32'h0000_0001 : per_cnt_ff;
    nxt_tune = tune_ff;
    ev = '0;
    ev[EV_ALARM] = alarm_set && !alarm_ff;
    ev[EV_PWR] = pwr_alarm;
    // Ramp one percent per step period; a zero period jumps straight to target
    if ((state_ff != ST_IDLE) && tick && (amp_ff < amp_set)) begin
      if (step_ff >= step_len) begin
        nxt_step = 8'h00;
        nxt_amp = amp_ff + 7'h01;
      end else begin
        nxt_step = step_ff + 8'h01;
      end
    end
    if ((state_ff != ST_IDLE) && (step_len == 8'h00)) nxt_amp = amp_set;
    if ((state_ff != ST_IDLE) && (amp_ff > amp_set)) nxt_amp = amp_set;
    case (state_ff)
      ST_IDLE: begin
        nxt_amp = 7'h00;
        nxt_step = 8'h00;
        nxt_seek_cnt = 16'h0000;
        if (start_rise && may_start) begin
          nxt_state = ST_WELD;
          nxt_ofs = ofs_set;
          nxt_per_cnt = 32'h0000_0000;
          ev[EV_START] = 1'b1;
        end else if ((seek_due || seek_rise) && !alarm_ff && !alarm_set) begin
          nxt_state = ST_SEEK;
          nxt_ofs = ofs_set;
          nxt_per_cnt = 32'h0000_0000;
        end
      end
      ST_WELD: begin
        if (alarm_set) begin
          nxt_state = ST_IDLE;
        end else if (!sync2_ff.start) begin
          nxt_state = ST_IDLE;
          ev[EV_END] = 1'b1;
          if (cfg_ff.ctrl[CTRL_EOC_STORE]) nxt_tune = meas_freq_in;
        end
      end
      ST_SEEK: begin
        if (tick) nxt_seek_cnt = seek_cnt_ff + 16'h0001;
        if (alarm_set) begin
          nxt_state = ST_IDLE;
        end else if (seek_cnt_ff >= cfg_ff.seek_time) begin
          nxt_state = ST_IDLE;
          nxt_tune = meas_freq_in;
          nxt_per_cnt = 32'h0000_0000;
          ev[EV_SEEK] = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Leaving a cycle drops amplitude on the same edge as the output
    if (nxt_state == ST_IDLE) nxt_amp = 7'h00;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      alarm_ff <= 1'b0;
      amp_ff <= 7'h00;
      ofs_ff <= 12'h000;
      step_ff <= 8'h00;
      seek_cnt_ff <= 16'h0000;
      per_cnt_ff <= 32'h0000_0000;
      tune_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      alarm_ff <= nxt_alarm;
      amp_ff <= nxt_amp;
      ofs_ff <= nxt_ofs;
      step_ff <= nxt_step;
      seek_cnt_ff <= nxt_seek_cnt;
      per_cnt_ff <= nxt_per_cnt;
      tune_ff <= nxt_tune;
    end
  end

  // Ready masks the trigger only in held mode; self-clearing accepts a fresh start
  assign sonics_on = (state_ff == ST_WELD);
  assign ready_out = (state_ff == ST_IDLE) && !(alarm_ff && cfg_ff.ctrl[CTRL_LATCH]);
  assign fault_out = alarm_ff;
  assign seek_scan_out = (state_ff == ST_SEEK);
  assign amp_level = amp_ff;
  assign freq_offset = ofs_ff;
endmodule : wcac_core

// file: tb/wcac_assertions.sv
// Port-level checks for the weld cycle and alarm controller.
// Assumes one clock and an active-low asynchronous reset; attached by bind.
`timescale 1ns/1ps
module wcac_assertions import wcac_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus and pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ext_start_in,
  input wire logic [ALARM_W-1:0] fault_cond_in,
  // Outputs
  input wire logic sonics_on,
  input wire logic ready_out,
  input wire logic fault_out,
  input wire logic seek_scan_out,
  input wire logic [6:0] amp_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_start_cause: assert property ($rose(sonics_on) |-> $past(ext_start_in, 2))
    else $error("output rose without a trigger");
  a_stop_drop: assert property ($fell(ext_start_in) |-> ##[1:5] !sonics_on)
    else $error("output outlived the trigger");
  a_held_refuse: assert property (fault_out && !ready_out |=> !$rose(sonics_on))
    else $error("cycle started over a held alarm");
  a_alarm_flag: assert property ((|fault_cond_in) [*5] |-> fault_out)
    else $error("fault output missing");
  a_alarm_stop: assert property (fault_out |-> !sonics_on)
    else $error("output on with alarm pending");
  a_seek_excl: assert property (seek_scan_out |-> !sonics_on && !ready_out)
    else $error("seek overlaps weld or ready");
  a_amp_end: assert property ($fell(sonics_on) |-> amp_level == 7'h00)
    else $error("amplitude not zero after cycle");
  a_amp_limit: assert property (amp_level <= AMP_MAX)
    else $error("amplitude above maximum");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  cover property ($rose(sonics_on));
  cover property (fault_out && !ready_out);
  cover property ($fell(seek_scan_out));
endmodule : wcac_assertions

bind wcac_core wcac_assertions chk_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ext_start_in(ext_start_in), .fault_cond_in(fault_cond_in), .sonics_on(sonics_on),
  .ready_out(ready_out), .fault_out(fault_out), .seek_scan_out(seek_scan_out), .amp_level(amp_level));

// file: tb/wcac_ctrl_model.sv
// Machine controller model on the user I/O side.
// Assumes bench requests change on clk; drives trigger and alarm-clear pins.
`timescale 1ns/1ps
module wcac_ctrl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench requests
  input wire logic want_weld,
  input wire logic rude,
  input wire logic want_clr,
  // Device pins
  input wire logic ready_out,
  output logic start,
  output logic clr
);
  logic start_ff, nxt_start, clr_ff, nxt_clr;
  // Rude ignores ready, only so the bench can show a refused start
  always_comb begin
    nxt_start = want_weld & (start_ff | ready_out | rude);
    nxt_clr = want_clr;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_ff <= 1'h0;
      clr_ff <= 1'h0;
    end else begin
      start_ff <= nxt_start;
      clr_ff <= nxt_clr;
    end
  end
  assign start = start_ff;
  assign clr = clr_ff;
endmodule : wcac_ctrl_model

// file: tb/tb_top.sv
// Self-checking bench for the weld cycle and alarm controller.
// Assumes package, core, checker and controller model are compiled first.
`timescale 1ns/1ps
module tb_top import wcac_pkg::*; ();
  logic clk, rst_b, cyc, we, key, line_ok, sup_ok, amp_v, ofs_v, want, rude, want_clr, start, clr, ack;
  logic seek_pin;
  logic [19:0] mfreq;
  logic sonics_on, ready_out, fault_out, seek_scan_out, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0] fault, sel;
  logic [6:0] amp_in, amp_level;
  logic [11:0] ofs_in, freq_offset;
  logic [7:0] raddr [6] = '{REG_CTRL, REG_AMP, REG_RAMP, REG_SEEK, REG_STATUS, 8'h3C};
  logic [31:0] rexp [6] = '{32'h0, 32'h64, 32'hA0A, 32'h32, 32'h12, 32'h0};
  int num_errors = 0, n_tests = 0, cyc_cnt = 0, t0;
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Short ticks keep the 60 s seek period and 1 s power window simulable
  wcac_core #(.TICK_CYCLES(10), .SEEK_PERIOD_TICKS(20), .POWER_SETTLE_TICKS(5)) dut (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_start_in(start), .ext_seek_in(seek_pin), .ext_fault_clr_in(clr),
    .panel_reset_key_in(key), .line_power_ok_in(line_ok), .logic_supply_ok_in(sup_ok), .fault_cond_in(fault),
    .amp_in_valid(amp_v), .ofs_in_valid(ofs_v), .amp_in(amp_in), .ofs_in(ofs_in), .meas_freq_in(mfreq),
    .sonics_on(sonics_on), .ready_out(ready_out), .fault_out(fault_out), .seek_scan_out(seek_scan_out),
    .amp_level(amp_level), .freq_offset(freq_offset), .irq(irq));
  wcac_ctrl_model ctl (.clk(clk), .rst_b(rst_b), .want_weld(want), .rude(rude), .want_clr(want_clr),
    .ready_out(ready_out), .start(start), .clr(clr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    sel <= 4'hF;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    rd = rdat;
    cyc <= 1'h0;
    we <= 1'h0;
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(s, v);
  endtask : wait_for
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    {rst_b, cyc, we, key, line_ok, sup_ok, amp_v, ofs_v, want, rude, want_clr, seek_pin} = '0;
    sel = 4'h0;
    mfreq = 20'h1ABCD;
    adr = 8'h00;
    wdat = 32'h0;
    fault = 4'h0;
    amp_in = 7'h3C;
    ofs_in = 12'h7FF;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    line_ok <= 1'h1;
    foreach (raddr[i]) rd_chk(raddr[i], rexp[i]);
    repeat (100) @(posedge clk);
    sup_ok <= 1'h1;
    repeat (10) @(posedge clk);
    chk(fault_out, 1'h0);
    $display("test reset done");
    wb(1'h1, REG_RAMP, 32'h0);
    wb(1'h1, REG_AMP, 32'h28);
    wb(1'h1, REG_AMP, 32'h05);
    rd_chk(REG_AMP, 32'h28);
    wb(1'h1, REG_OFS, 32'h123);
    wb(1'h1, REG_CTRL, 32'h08);
    want <= 1'h1;
    wait_for(sonics_on, 1'h1);
    repeat (5) @(posedge clk);
    chk(amp_level, 32'h28);
    chk(freq_offset, 32'h123);
    want <= 1'h0;
    wait_for(sonics_on, 1'h0);
    rd_chk(REG_TUNE, 32'h1ABCD);
    rd_chk(REG_IRQ_ST, 32'h06);
    wb(1'h1, REG_IRQ_MASK, 32'h04);
    @(posedge clk);
    chk(irq, 1'h1);
    wb(1'h1, REG_IRQ_ST, 32'h06);
    @(posedge clk);
    chk(irq, 1'h0);
    $display("test weld done");
    wb(1'h1, REG_CTRL, 32'h06);
    for (int i = 0; i < 2; i++) begin
      amp_v <= (i == 0);
      ofs_v <= (i == 0);
      want <= 1'h1;
      wait_for(sonics_on, 1'h1);
      repeat (5) @(posedge clk);
      chk(amp_level, (i == 0) ? 32'h3C : 32'h32);
      chk(freq_offset, (i == 0) ? 32'h7FF : 32'h0);
      want <= 1'h0;
      wait_for(sonics_on, 1'h0);
    end
    $display("test analog done");
    wb(1'h1, REG_CTRL, 32'h0);
    want <= 1'h1;
    wait_for(sonics_on, 1'h1);
    fault <= 4'h4;
    wait_for(fault_out, 1'h1);
    chk(sonics_on, 1'h0);
    fault <= 4'h0;
    repeat (8) @(posedge clk);
    chk(sonics_on, 1'h0);
    want <= 1'h0;
    repeat (6) @(posedge clk);
    want <= 1'h1;
    wait_for(sonics_on, 1'h1);
    chk(fault_out, 1'h0);
    want <= 1'h0;
    wait_for(sonics_on, 1'h0);
    $display("test self-clearing done");
    wb(1'h1, REG_CTRL, 32'h01);
    for (int k = 0; k < 2; k++) begin
      fault <= 4'h1;
      wait_for(fault_out, 1'h1);
      fault <= 4'h0;
      repeat (5) @(posedge clk);
      chk(ready_out, 1'h0);
      want <= 1'h1;
      repeat (8) @(posedge clk);
      chk(start, 1'h0);
      rude <= 1'h1;
      repeat (8) @(posedge clk);
      chk(sonics_on, 1'h0);
      want <= 1'h0;
      rude <= 1'h0;
      key <= (k == 0);
      want_clr <= (k == 1);
      wait_for(fault_out, 1'h0);
      key <= 1'h0;
      want_clr <= 1'h0;
      wait_for(ready_out, 1'h1);
    end
    $display("test held done");
    wb(1'h1, REG_SEEK, 32'h2);
    wb(1'h1, REG_CTRL, 32'h10);
    wait_for(seek_scan_out, 1'h1);
    wait_for(seek_scan_out, 1'h0);
    want <= 1'h1;
    wait_for(sonics_on, 1'h1);
    t0 = cyc_cnt;
    want <= 1'h0;
    mfreq <= 20'h2468A;
    wait_for(seek_scan_out, 1'h1);
    chk((cyc_cnt - t0) inside {[185:215]}, 32'h1);
    t0 = cyc_cnt;
    wait_for(seek_scan_out, 1'h0);
    chk((cyc_cnt - t0) inside {[11:22]}, 32'h1);
    rd_chk(REG_TUNE, 32'h2468A);
    $display("test seek done");
    wb(1'h1, REG_CTRL, 32'h0);
    seek_pin <= 1'h1;
    wait_for(seek_scan_out, 1'h1);
    chk(sonics_on, 1'h0);
    seek_pin <= 1'h0;
    wait_for(seek_scan_out, 1'h0);
    sup_ok <= 1'h0;
    line_ok <= 1'h0;
    repeat (10) @(posedge clk);
    line_ok <= 1'h1;
    repeat (10) @(posedge clk);
    sup_ok <= 1'h1;
    wait_for(fault_out, 1'h1);
    $display("test power done");
    end_of_test();
  end
endmodule : tb_top
